// file: hw/etm_pkg.sv
package etm_pkg;
  // Register groups; byte offset is group * 2 + channel
  localparam logic [2:0] GRP_CTRL = 3'h0;
  localparam logic [2:0] GRP_CSR  = 3'h1;
  localparam logic [2:0] GRP_CMPA = 3'h2;
  localparam logic [2:0] GRP_CMPB = 3'h3;
  localparam logic [2:0] GRP_CNT  = 3'h4;
  localparam logic [2:0] GRP_CCTL = 3'h5;
  // timer_control fields
  localparam int CTRL_MB_IE = 7;
  localparam int CTRL_MA_IE = 6;
  localparam int CTRL_OV_IE = 5;
  localparam int CTRL_CLR_H = 4;
  localparam int CTRL_CLR_L = 3;
  localparam int CTRL_CKS_H = 2;
  // control_status fields
  localparam int CSR_FB    = 7;
  localparam int CSR_FA    = 6;
  localparam int CSR_FOV   = 5;
  localparam int CSR_OSB_H = 3;
  localparam int CSR_OSB_L = 2;
  localparam int CSR_OSA_H = 1;
  // counter_control fields
  localparam int CCTL_RIS  = 3;
  localparam int CCTL_ICK1 = 1;
  localparam int CCTL_ICK0 = 0;
  localparam logic [7:0] CCTL_MASK = 8'h0b;
  // Reset values and counter maximum
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] CMP_RST  = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CNT_MAX  = 8'hff;
  // Prescaler width and taps (tap k divides by 2^(k+1))
  localparam int PRE_W    = 13;
  localparam int TAP_D2   = 0;
  localparam int TAP_D8   = 2;
  localparam int TAP_D32  = 4;
  localparam int TAP_D64  = 5;
  localparam int TAP_D1K  = 9;
  localparam int TAP_D8K  = 12;

  typedef enum logic [1:0] {
    CLR_NONE = 2'h0, CLR_MA = 2'h1, CLR_MB = 2'h2, CLR_EXT = 2'h3
  } etm_clr_e;
  typedef enum logic [2:0] {
    CK_STOP = 3'h0, CK_INT1 = 3'h1, CK_INT2 = 3'h2, CK_INT3 = 3'h3,
    CK_CASC = 3'h4, CK_EXT_R = 3'h5, CK_EXT_F = 3'h6, CK_EXT_B = 3'h7
  } etm_cks_e;
  typedef enum logic [1:0] {
    OUT_KEEP = 2'h0, OUT_LOW = 2'h1, OUT_HIGH = 2'h2, OUT_TOG = 2'h3
  } etm_out_e;
endpackage

// file: hw/etm_timer.sv
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Counter is 8-bit, read/write, counts up
// - Word access joins counters, channel 0 high
// - Clear select: none, match A, B, external
// - External clear: rising edge or high level
// - Wrap from all ones sets overflow flag
// - Counter equal compare A sets flag A
// - Counter equal compare B sets flag B
// - Writing compare A masks its match
// - Writing compare B masks its match
// - Match A drives pin per select A
// - Match B drives pin per select B
// - Match B request needs enable bit 7
// - Match A request needs enable bit 6
// - Overflow request needs enable bit 5
// - Clock select bits pick source, edge
// - Reset loads compare registers all ones
// - Reset loads counter with zero
// - Channel 0 cascades on channel 1 overflow
// - Channel 1 counts channel 0 match A
module etm_timer
  import etm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_word,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [15:0] bus_rdata,
  input  wire logic [1:0]  ext_count_clock_pin,
  input  wire logic [1:0]  ext_counter_reset_pin,
  output logic      [1:0]  compare_output_pin,
  output logic      [1:0]  match_a_irq,
  output logic      [1:0]  match_b_irq,
  output logic      [1:0]  overflow_irq
);

  typedef struct packed {
    logic [1:0][7:0]       cnt;
    logic [1:0][7:0]       cora;
    logic [1:0][7:0]       corb;
    logic [1:0][7:0]       ctrl;
    logic [1:0][7:0]       cctl;
    logic [1:0]            fa;
    logic [1:0]            fb;
    logic [1:0]            fov;
    logic [1:0][1:0]       osa;
    logic [1:0][1:0]       osb;
    logic [1:0]            pin;
    logic [1:0]            ovp;
    logic [1:0]            cmap;
    logic [PRE_W-1:0]      pre;
    logic [1:0]            ck1;
    logic [1:0]            ck2;
    logic [1:0]            ck3;
    logic [1:0]            rs1;
    logic [1:0]            rs2;
    logic [1:0]            rs3;
    logic [1:0]            irq_a;
    logic [1:0]            irq_b;
    logic [1:0]            irq_o;
    logic [15:0]           rdata;
  } etm_state_s;

  etm_state_s s_q;
  etm_state_s s_d;
  logic [1:0] tick;
  logic [1:0] eq_a;
  logic [1:0] eq_b;
  logic [1:0] cm_a;
  logic [1:0] cm_b;
  logic [1:0] ext_clr;
  logic [1:0] mt_clr;
  logic [1:0] ovf;
  logic [1:0][7:0] wb;

  // Word access ignores address bit 0 and reaches both channels
  function automatic logic wr_hit(input logic [2:0] g, input logic c);
    return bus_wr && (bus_addr[3:1] == g) && (bus_word || (bus_addr[0] == c));
  endfunction

  function automatic logic [7:0] wbyte(input logic c);
    if (bus_word) begin
      return c ? bus_wdata[7:0] : bus_wdata[15:8];
    end
    return bus_wdata[7:0];
  endfunction

  function automatic logic [7:0] rd_byte(input logic [2:0] g, input logic c);
    case (g)
      GRP_CTRL: return s_q.ctrl[c];
      GRP_CSR:  return {s_q.fb[c], s_q.fa[c], s_q.fov[c], 1'b0, s_q.osb[c], s_q.osa[c]};
      GRP_CMPA: return s_q.cora[c];
      GRP_CMPB: return s_q.corb[c];
      GRP_CNT:  return s_q.cnt[c];
      GRP_CCTL: return s_q.cctl[c] & CCTL_MASK;
      default:  return 8'h00;
    endcase
  endfunction

  // Internal taps count on the prescaler bit edge, so a rate is exact whatever the phase
  function automatic logic tick_of(input logic [2:0] cks, input logic [7:0] cc,
                                   input logic casc, input logic cr, input logic cf);
    int   t;
    logic ed;
    t  = TAP_D8K;
    ed = 1'b0;
    case (cks)
      CK_INT1: t = cc[CCTL_ICK0] ? TAP_D2 : TAP_D8;
      CK_INT2: t = cc[CCTL_ICK0] ? TAP_D32 : TAP_D64;
      default: t = cc[CCTL_ICK0] ? TAP_D1K : TAP_D8K;
    endcase
    if (cc[CCTL_ICK1]) begin
      ed = s_q.pre[t] && !s_d.pre[t];
    end else begin
      ed = !s_q.pre[t] && s_d.pre[t];
    end
    case (cks)
      CK_STOP:  return 1'b0;
      CK_CASC:  return casc;
      CK_EXT_R: return cr;
      CK_EXT_F: return cf;
      CK_EXT_B: return cr || cf;
      default:  return ed;
    endcase
  endfunction

  function automatic logic out_act(input logic [1:0] sel, input logic p);
    case (sel)
      OUT_LOW:  return 1'b0;
      OUT_HIGH: return 1'b1;
      OUT_TOG:  return !p;
      default:  return p;
    endcase
  endfunction

  always_comb begin
    s_d     = s_q;
    tick    = 2'h0;
    eq_a    = 2'h0;
    eq_b    = 2'h0;
    cm_a    = 2'h0;
    cm_b    = 2'h0;
    ext_clr = 2'h0;
    mt_clr  = 2'h0;
    ovf     = 2'h0;
    wb      = '0;
    s_d.pre = s_q.pre + 1'b1;
    s_d.ck1 = ext_count_clock_pin;
    s_d.ck2 = s_q.ck1;
    s_d.ck3 = s_q.ck2;
    s_d.rs1 = ext_counter_reset_pin;
    s_d.rs2 = s_q.rs1;
    s_d.rs3 = s_q.rs2;
    for (int c = 0; c < 2; c++) begin
      wb[c] = wbyte(1'(c));
      // Cascade events are taken from last cycle's pulses to break the loop
      tick[c] = tick_of(s_q.ctrl[c][CTRL_CKS_H:0], s_q.cctl[c],
                        (c == 0) ? s_q.ovp[1] : s_q.cmap[0],
                        s_q.ck2[c] && !s_q.ck3[c],
                        !s_q.ck2[c] && s_q.ck3[c]);
      eq_a[c] = (s_q.cnt[c] == s_q.cora[c]) && !wr_hit(GRP_CMPA, 1'(c));
      eq_b[c] = (s_q.cnt[c] == s_q.corb[c]) && !wr_hit(GRP_CMPB, 1'(c));
      cm_a[c] = eq_a[c] && tick[c];
      cm_b[c] = eq_b[c] && tick[c];
      case (etm_clr_e'(s_q.ctrl[c][CTRL_CLR_H:CTRL_CLR_L]))
        CLR_MA:  mt_clr[c] = cm_a[c];
        CLR_MB:  mt_clr[c] = cm_b[c];
        CLR_EXT: ext_clr[c] = s_q.cctl[c][CCTL_RIS] ? s_q.rs2[c]
                              : (s_q.rs2[c] && !s_q.rs3[c]);
        default: mt_clr[c] = 1'b0;
      endcase
      ovf[c] = tick[c] && !mt_clr[c] && !ext_clr[c] && (s_q.cnt[c] == CNT_MAX);
      if (wr_hit(GRP_CNT, 1'(c))) begin
        s_d.cnt[c] = wbyte(1'(c));
      end else if (ext_clr[c] || mt_clr[c]) begin
        s_d.cnt[c] = 8'h00;
      end else if (tick[c]) begin
        s_d.cnt[c] = s_q.cnt[c] + 8'h01;
      end
      if (wr_hit(GRP_CMPA, 1'(c))) begin
        s_d.cora[c] = wbyte(1'(c));
      end
      if (wr_hit(GRP_CMPB, 1'(c))) begin
        s_d.corb[c] = wbyte(1'(c));
      end
      if (wr_hit(GRP_CTRL, 1'(c))) begin
        s_d.ctrl[c] = wbyte(1'(c));
      end
      if (wr_hit(GRP_CCTL, 1'(c))) begin
        s_d.cctl[c] = wbyte(1'(c)) & CCTL_MASK;
      end
      // Flags clear by writing 0; a write of 1 leaves them, and a new event wins
      if (wr_hit(GRP_CSR, 1'(c))) begin
        s_d.fb[c]  = s_q.fb[c] && wb[c][CSR_FB];
        s_d.fa[c]  = s_q.fa[c] && wb[c][CSR_FA];
        s_d.fov[c] = s_q.fov[c] && wb[c][CSR_FOV];
        s_d.osb[c] = wb[c][CSR_OSB_H:CSR_OSB_L];
        s_d.osa[c] = wb[c][CSR_OSA_H:0];
      end
      if (eq_a[c]) begin
        s_d.fa[c] = 1'b1;
      end
      if (eq_b[c]) begin
        s_d.fb[c] = 1'b1;
      end
      if (ovf[c]) begin
        s_d.fov[c] = 1'b1;
      end
      s_d.ovp[c]  = ovf[c];
      s_d.cmap[c] = cm_a[c];
      // Match A acts after match B, on the pin value B left, when both land together
      if (cm_b[c]) begin
        s_d.pin[c] = out_act(s_q.osb[c], s_q.pin[c]);
      end
      if (cm_a[c]) begin
        s_d.pin[c] = out_act(s_q.osa[c], cm_b[c] ? s_d.pin[c] : s_q.pin[c]);
      end
      s_d.irq_b[c] = s_d.ctrl[c][CTRL_MB_IE] && s_d.fb[c];
      s_d.irq_a[c] = s_d.ctrl[c][CTRL_MA_IE] && s_d.fa[c];
      s_d.irq_o[c] = s_d.ctrl[c][CTRL_OV_IE] && s_d.fov[c];
    end
    s_d.rdata = 16'h0000;
    if (bus_rd) begin
      if (bus_word) begin
        s_d.rdata = {rd_byte(bus_addr[3:1], 1'b0), rd_byte(bus_addr[3:1], 1'b1)};
      end else begin
        s_d.rdata = {8'h00, rd_byte(bus_addr[3:1], bus_addr[0])};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q       <= '0;
      s_q.cnt   <= {CNT_RST, CNT_RST};
      s_q.cora  <= {CMP_RST, CMP_RST};
      s_q.corb  <= {CMP_RST, CMP_RST};
      s_q.ctrl  <= {CTRL_RST, CTRL_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata          = s_q.rdata;
  assign compare_output_pin = s_q.pin;
  assign match_a_irq        = s_q.irq_a;
  assign match_b_irq        = s_q.irq_b;
  assign overflow_irq       = s_q.irq_o;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_plain_tick0;
    tick[0] && !mt_clr[0] && !ext_clr[0] && !wr_hit(GRP_CNT, 1'b0);
  endsequence
  sequence s_plain_tick1;
    tick[1] && !mt_clr[1] && !ext_clr[1] && !wr_hit(GRP_CNT, 1'b1);
  endsequence
  sequence s_casc0;
    (s_q.ctrl[0][CTRL_CKS_H:0] == CK_CASC) && ovf[1];
  endsequence

  a_cnt_step: assert property (s_plain_tick0 |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 8'h01)
    else $error("counter did not step by one");
  a_word_read: assert property ((bus_rd && bus_word && bus_addr[3:1] == GRP_CNT)
                 |=> bus_rdata == {$past(s_q.cnt[0]), $past(s_q.cnt[1])})
    else $error("word read of counters wrong");
  a_clear_match: assert property ((s_q.ctrl[0][CTRL_CLR_H:CTRL_CLR_L] == CLR_MA && cm_a[0]
                   && !wr_hit(GRP_CNT, 1'b0)) |=> s_q.cnt[0] == 8'h00)
    else $error("match A did not clear counter");
  a_ext_level: assert property ((s_q.ctrl[1][CTRL_CLR_H:CTRL_CLR_L] == CLR_EXT
                 && s_q.cctl[1][CCTL_RIS] && s_q.rs2[1] && !wr_hit(GRP_CNT, 1'b1))
                 |=> s_q.cnt[1] == 8'h00)
    else $error("level reset did not clear counter");
  a_ovf_flag: assert property (s_plain_tick0 and (s_q.cnt[0] == CNT_MAX)
                |=> s_q.fov[0] && s_q.cnt[0] == 8'h00)
    else $error("wrap did not set overflow flag");
  a_flag_a: assert property (eq_a[1] |=> s_q.fa[1])
    else $error("match A flag not set");
  a_flag_b: assert property (eq_b[0] |=> s_q.fb[0])
    else $error("match B flag not set");
  a_cmpa_quiet: assert property ((wr_hit(GRP_CMPA, 1'b0) && !s_q.fa[0]) |=> !s_q.fa[0])
    else $error("match A seen during compare write");
  a_cmpb_quiet: assert property ((wr_hit(GRP_CMPB, 1'b1) && !s_q.fb[1]) |=> !s_q.fb[1])
    else $error("match B seen during compare write");
  a_pin_high: assert property ((cm_a[0] && s_q.osa[0] == OUT_HIGH) |=> compare_output_pin[0])
    else $error("pin not driven high on match A");
  a_pin_tog_b: assert property ((cm_b[1] && !cm_a[1] && s_q.osb[1] == OUT_TOG)
                 |=> compare_output_pin[1] != $past(compare_output_pin[1]))
    else $error("pin not toggled on match B");
  a_irq_b: assert property (match_b_irq[0] == (s_q.ctrl[0][CTRL_MB_IE] && s_q.fb[0]))
    else $error("match B request not gated by enable");
  a_irq_a: assert property (match_a_irq[1] == (s_q.ctrl[1][CTRL_MA_IE] && s_q.fa[1]))
    else $error("match A request not gated by enable");
  a_irq_ov: assert property (overflow_irq[0] == (s_q.ctrl[0][CTRL_OV_IE] && s_q.fov[0]))
    else $error("overflow request not gated by enable");
  a_stop_hold: assert property ((s_q.ctrl[0][CTRL_CKS_H:0] == CK_STOP) |-> !tick[0])
    else $error("stopped counter ticked");
  a_reset_vals: assert property ($past(reset) |-> s_q.cnt == '0
                  && s_q.cora == {CMP_RST, CMP_RST})
    else $error("reset values wrong");
  a_cascade: assert property (s_casc0 |=> (s_q.ctrl[0][CTRL_CKS_H:0] != CK_CASC) || tick[0])
    else $error("cascade did not advance channel 0");
  a_match_cnt: assert property (((s_q.ctrl[1][CTRL_CKS_H:0] == CK_CASC) && cm_a[0])
                 |=> (s_q.ctrl[1][CTRL_CKS_H:0] != CK_CASC) || tick[1])
    else $error("channel 1 missed match A count");
  a_cnt_step1: assert property (s_plain_tick1
                 |=> s_q.cnt[1] == $past(s_q.cnt[1]) + 8'h01)
    else $error("counter 1 did not step by one");
  a_cnt_write: assert property ((wr_hit(GRP_CNT, 1'b0) && !bus_word)
                 |=> s_q.cnt[0] == $past(bus_wdata[7:0]))
    else $error("byte write of counter lost");
  a_word_write: assert property ((bus_wr && bus_word && bus_addr[3:1] == GRP_CNT)
                  |=> s_q.cnt[0] == $past(bus_wdata[15:8]) && s_q.cnt[1] == $past(bus_wdata[7:0]))
    else $error("word write of counters wrong");
  a_clear_mb: assert property ((s_q.ctrl[1][CTRL_CLR_H:CTRL_CLR_L] == CLR_MB && cm_b[1]
                && !wr_hit(GRP_CNT, 1'b1)) |=> s_q.cnt[1] == 8'h00)
    else $error("match B did not clear counter");
  a_no_clear: assert property ((s_q.ctrl[0][CTRL_CLR_H:CTRL_CLR_L] == CLR_NONE && tick[0]
                && !wr_hit(GRP_CNT, 1'b0)) |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 8'h01)
    else $error("counter cleared with clearing off");
  a_ext_edge: assert property ((s_q.ctrl[0][CTRL_CLR_H:CTRL_CLR_L] == CLR_EXT
                && !s_q.cctl[0][CCTL_RIS] && s_q.rs2[0] && !s_q.rs3[0] && !wr_hit(GRP_CNT, 1'b0))
                |=> s_q.cnt[0] == 8'h00)
    else $error("edge reset did not clear counter");
  a_ovf_flag1: assert property (s_plain_tick1 and (s_q.cnt[1] == CNT_MAX)
                 |=> s_q.fov[1])
    else $error("wrap did not set overflow flag 1");
  a_flag_a0: assert property (eq_a[0]
               |=> s_q.fa[0])
    else $error("match A flag 0 not set");
  a_flag_b1: assert property (eq_b[1]
               |=> s_q.fb[1])
    else $error("match B flag 1 not set");
  a_cmpa_quiet1: assert property ((wr_hit(GRP_CMPA, 1'b1) && !s_q.fa[1])
                   |=> !s_q.fa[1])
    else $error("match A seen during compare write");
  a_cmpb_quiet0: assert property ((wr_hit(GRP_CMPB, 1'b0) && !s_q.fb[0])
                   |=> !s_q.fb[0])
    else $error("match B seen during compare write");
  a_pin_low_a: assert property ((cm_a[1] && s_q.osa[1] == OUT_LOW)
                 |=> !compare_output_pin[1])
    else $error("pin not driven low on match A");
  a_pin_keep: assert property ((!cm_a[0] && !cm_b[0])
                |=> compare_output_pin[0] == $past(compare_output_pin[0]))
    else $error("pin moved without a match");
  a_pin_low_b: assert property ((cm_b[0] && !cm_a[0] && s_q.osb[0] == OUT_LOW)
                 |=> !compare_output_pin[0])
    else $error("pin not driven low on match B");
  a_irq_b1: assert property (match_b_irq[1]
              == (s_q.ctrl[1][CTRL_MB_IE] && s_q.fb[1]))
    else $error("match B request 1 not gated by enable");
  a_irq_a0: assert property (match_a_irq[0]
              == (s_q.ctrl[0][CTRL_MA_IE] && s_q.fa[0]))
    else $error("match A request 0 not gated by enable");
  a_irq_ov1: assert property (overflow_irq[1]
               == (s_q.ctrl[1][CTRL_OV_IE] && s_q.fov[1]))
    else $error("overflow request 1 not gated by enable");
  a_stop_hold1: assert property ((s_q.ctrl[1][CTRL_CKS_H:0] == CK_STOP)
                  |-> !tick[1])
    else $error("stopped counter 1 ticked");
  a_ext_rise: assert property ((s_q.ctrl[0][CTRL_CKS_H:0] == CK_EXT_R)
                |-> tick[0] == (s_q.ck2[0] && !s_q.ck3[0]))
    else $error("external rising edge not counted");
  a_reset_cmpb: assert property ($past(reset)
                  |-> s_q.corb == {CMP_RST, CMP_RST} && compare_output_pin == 2'h0)
    else $error("reset values of compare B wrong");
  a_casc_stop: assert property ((s_q.ctrl[0][CTRL_CKS_H:0] == CK_CASC && !s_q.ovp[1])
                 |-> !tick[0])
    else $error("cascade ticked without overflow");
  a_rd_idle: assert property (!bus_rd
               |=> bus_rdata == 16'h0000)
    else $error("read data not idle after no read");

endmodule // etm_timer

// file: tb/etm_pin_model.sv
`timescale 1ns/1ps
module etm_pin_model (
  input  wire logic       clock,
  output logic      [1:0] ext_count_clock_pin,
  output logic      [1:0] ext_counter_reset_pin,
  input  wire logic [1:0] compare_output_pin
);
  initial begin
    ext_count_clock_pin   = 2'h0;
    ext_counter_reset_pin = 2'h0;
  end

  // Pulses are 4 clocks wide: narrower ones may slip past the two-flop sampling
  task pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge clock);
      ext_count_clock_pin[ch] <= 1'b1;
      repeat (4) @(posedge clock);
      ext_count_clock_pin[ch] <= 1'b0;
      repeat (4) @(posedge clock);
    end
    // Let the last edge pass the synchroniser before anyone looks
    repeat (4) @(posedge clock);
  endtask

  task level(input int ch, input logic v);
    @(posedge clock);
    ext_counter_reset_pin[ch] <= v;
  endtask
endmodule // etm_pin_model

// file: tb/test_eight_bit_dual_compare_timer.sv
`timescale 1ns/1ps
module test_eight_bit_dual_compare_timer
  import etm_pkg::*;
  ;
  logic        clock;
  logic        reset;
  logic        bus_word;
  logic        bus_wr;
  logic        bus_rd;
  logic [3:0]  bus_addr;
  logic [15:0] bus_wdata;
  logic [15:0] bus_rdata;
  logic [15:0] seen;
  logic [1:0]  ext_count_clock_pin;
  logic [1:0]  ext_counter_reset_pin;
  logic [1:0]  compare_output_pin;
  logic [1:0]  match_a_irq;
  logic [1:0]  match_b_irq;
  logic [1:0]  overflow_irq;
  int          mismatches;
  int          compares;

  etm_timer u_etm_timer (
    .clock(clock), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_word(bus_word), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ext_count_clock_pin(ext_count_clock_pin), .ext_counter_reset_pin(ext_counter_reset_pin),
    .compare_output_pin(compare_output_pin), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq), .overflow_irq(overflow_irq)
  );

  etm_pin_model u_etm_pin_model (
    .clock(clock), .ext_count_clock_pin(ext_count_clock_pin),
    .ext_counter_reset_pin(ext_counter_reset_pin), .compare_output_pin(compare_output_pin)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task final_report;
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task wr(input logic [2:0] grp, input logic ch, input logic w, input logic [15:0] d);
    @(posedge clock);
    bus_addr  <= {grp, ch};
    bus_wdata <= d;
    bus_word  <= w;
    bus_wr    <= 1'b1;
    @(posedge clock);
    bus_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task rd(input logic [2:0] grp, input logic ch, input logic w);
    @(posedge clock);
    bus_addr <= {grp, ch};
    bus_word <= w;
    bus_rd   <= 1'b1;
    @(posedge clock);
    bus_rd   <= 1'b0;
    #1;
    seen = bus_rdata;
  endtask

  task rc(input logic [2:0] grp, input logic ch, input logic w, input logic [15:0] exp,
          input string what);
    rd(grp, ch, w);
    chk(what, seen, exp);
  endtask

  task t_reset;
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0000, "cnt0 reset");
    rc(GRP_CMPA, 1'b1, 1'b0, 16'h00ff, "cmpa1 reset");
    rc(GRP_CMPB, 1'b0, 1'b0, 16'h00ff, "cmpb0 reset");
    rc(3'h6, 1'b0, 1'b0, 16'h0000, "unmapped");
    $display("test reset values finished");
  endtask

  task t_word;
    wr(GRP_CNT, 1'b0, 1'b1, 16'h1234);
    rc(GRP_CNT, 1'b0, 1'b1, 16'h1234, "cnt word");
    rc(GRP_CNT, 1'b1, 1'b0, 16'h0034, "cnt1 byte");
    wr(GRP_CNT, 1'b1, 1'b0, 16'h00a5);
    rc(GRP_CNT, 1'b0, 1'b1, 16'h12a5, "cnt1 write");
    $display("test word access finished");
  endtask

  task t_ext;
    wr(GRP_CNT, 1'b0, 1'b0, 16'h0000);
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0005);
    u_etm_pin_model.pulse(0, 3);
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0003, "ext rising");
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0006);
    u_etm_pin_model.pulse(0, 2);
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0005, "ext falling");
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0007);
    u_etm_pin_model.pulse(0, 1);
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0007, "ext both");
    $display("test external clock finished");
  endtask

  task t_int;
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0000);
    wr(GRP_CNT, 1'b0, 1'b0, 16'h0000);
    wr(GRP_CCTL, 1'b0, 1'b0, 16'h0001);
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0001);
    wt(20);
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0000);
    rd(GRP_CNT, 1'b0, 1'b0);
    chk("div2 high", {8'h00, seen[15:8]}, 16'h0000);
    // About 22 clocks of counting, 11 ticks; the range leaves two ticks of slack either way
    chk("div2 range", {15'h0000, (seen[7:0] >= 8'h09 && seen[7:0] <= 8'h0d)}, 16'h0001);
    wr(GRP_CCTL, 1'b0, 1'b0, 16'h0000);
    $display("test internal clock finished");
  endtask

  task t_ovf;
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0005);
    wr(GRP_CNT, 1'b0, 1'b0, 16'h00ff);
    u_etm_pin_model.pulse(0, 1);
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0000, "cnt wrap");
    // Counter sat at ff, equal to both reset compares, so both match flags rise too
    rc(GRP_CSR, 1'b0, 1'b0, 16'h00e0, "ovf flag");
    chk("ovf irq masked", {15'h0000, overflow_irq[0]}, 16'h0000);
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0025);
    wt(2);
    chk("ovf irq", {15'h0000, overflow_irq[0]}, 16'h0001);
    wr(GRP_CSR, 1'b0, 1'b0, 16'h0000);
    wt(2);
    chk("ovf irq clr", {15'h0000, overflow_irq[0]}, 16'h0000);
    $display("test overflow finished");
  endtask

  task t_match;
    wr(GRP_CMPA, 1'b0, 1'b0, 16'h0002);
    wr(GRP_CSR, 1'b0, 1'b0, 16'h0003);
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h004d);
    u_etm_pin_model.pulse(0, 2);
    wt(1);
    chk("irq a", {15'h0000, match_a_irq[0]}, 16'h0001);
    rc(GRP_CSR, 1'b0, 1'b0, 16'h0043, "flag a");
    u_etm_pin_model.pulse(0, 1);
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0000, "clear a");
    chk("pin toggle", {15'h0000, compare_output_pin[0]}, 16'h0001);
    wr(GRP_CMPB, 1'b0, 1'b0, 16'h0001);
    wr(GRP_CSR, 1'b0, 1'b0, 16'h0004);
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0095);
    u_etm_pin_model.pulse(0, 1);
    wt(1);
    chk("irq b", {15'h0000, match_b_irq[0]}, 16'h0001);
    chk("irq a off", {15'h0000, match_a_irq[0]}, 16'h0000);
    u_etm_pin_model.pulse(0, 1);
    rc(GRP_CSR, 1'b0, 1'b0, 16'h0084, "flag b");
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0000, "clear b");
    chk("pin low", {15'h0000, compare_output_pin[0]}, 16'h0000);
    $display("test compare match finished");
  endtask

  task t_ext_rst;
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0018);
    wr(GRP_CNT, 1'b0, 1'b0, 16'h0050);
    u_etm_pin_model.level(0, 1'b1);
    wt(6);
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0000, "edge clear");
    wr(GRP_CNT, 1'b0, 1'b0, 16'h0040);
    wt(4);
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0040, "edge only once");
    wr(GRP_CCTL, 1'b0, 1'b0, 16'h00f8);
    rc(GRP_CCTL, 1'b0, 1'b0, 16'h0008, "cctl reserved");
    wt(4);
    rc(GRP_CNT, 1'b0, 1'b0, 16'h0000, "level clear");
    u_etm_pin_model.level(0, 1'b0);
    wr(GRP_CCTL, 1'b0, 1'b0, 16'h0000);
    $display("test external reset finished");
  endtask

  task t_cascade;
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0004);
    wr(GRP_CTRL, 1'b1, 1'b0, 16'h0005);
    wr(GRP_CNT, 1'b0, 1'b1, 16'h00ff);
    u_etm_pin_model.pulse(1, 1);
    rc(GRP_CNT, 1'b0, 1'b1, 16'h0100, "cascade ovf");
    wr(GRP_CMPA, 1'b0, 1'b0, 16'h0001);
    wr(GRP_CTRL, 1'b0, 1'b0, 16'h0005);
    wr(GRP_CTRL, 1'b1, 1'b0, 16'h0004);
    u_etm_pin_model.pulse(0, 1);
    rc(GRP_CNT, 1'b0, 1'b1, 16'h0201, "cascade match");
    $display("test cascade finished");
  endtask

  initial begin
    #(40 * 5000);
    mismatches++;
    final_report;
  end

  initial begin
    mismatches = 0;
    compares   = 0;
    reset      = 1'b1;
    bus_addr   = 4'h0;
    bus_wdata  = 16'h0000;
    bus_word   = 1'b0;
    bus_wr     = 1'b0;
    bus_rd     = 1'b0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_word;
    t_ext;
    t_int;
    t_ovf;
    t_match;
    t_ext_rst;
    t_cascade;
    final_report;
  end
endmodule // test_eight_bit_dual_compare_timer
